//--- pkg/adcsq_regs.svh
`ifndef ADCSQ_REGS_SVH
`define ADCSQ_REGS_SVH

// register indices; byte address is four times the index
`define ADCSQ_IDX_RES_LO 8'h19
`define ADCSQ_IDX_RES_HI 8'h1A
`define ADCSQ_IDX_CHREF 8'h1B
`define ADCSQ_IDX_TRIGCFG 8'h1C
`define ADCSQ_IDX_CTRL 8'h1D
`define ADCSQ_IDX_NONE 8'h00

// conversion_control_status fields
`define ADCSQ_CTRL_EN 7
`define ADCSQ_CTRL_START 6
`define ADCSQ_CTRL_ATE 5
`define ADCSQ_CTRL_FLAG 4
`define ADCSQ_CTRL_IE 3
`define ADCSQ_CTRL_PS_MSB 2
`define ADCSQ_CTRL_PS_LSB 0

// channel_reference_select fields
`define ADCSQ_CHREF_REF_MSB 7
`define ADCSQ_CHREF_REF_LSB 6
`define ADCSQ_CHREF_CH_MSB 2
`define ADCSQ_CHREF_CH_LSB 0

// trigger_alignment_config fields
`define ADCSQ_TRIG_LADJ 7
`define ADCSQ_TRIG_TS_MSB 2
`define ADCSQ_TRIG_TS_LSB 0

// reset values
`define ADCSQ_RST_BYTE 8'h00
`define ADCSQ_RST_RESULT 10'h000

// reference codes
`define ADCSQ_REF_SUPPLY 2'h0
`define ADCSQ_REF_1V1 2'h1
`define ADCSQ_REF_2V2 2'h2
`define ADCSQ_REF_4V3 2'h3

// trigger source free-running code
`define ADCSQ_TS_FREE 3'h0

// conversion lengths in converter clock cycles
`define ADCSQ_CONV_FIRST_CYC 5'h19
`define ADCSQ_CONV_NORM_CYC 5'h0D

`endif

//--- pkg/adcsq_pkg.sv
package adcsq_pkg;
   typedef enum logic {ST_IDLE, ST_CONV} adcsq_state_e;
   typedef logic [9:0] adcsq_code_t;
   typedef logic [7:0] adcsq_byte_t;
endpackage : adcsq_pkg

//--- core/adcsq_prescaler.sv
`timescale 1ns/1ps
`include "adcsq_regs.svh"

module adcsq_prescaler #(
   parameter int DIV_W = 7
) (
   input wire logic clk, // system clock
   input wire logic sys_rst, // synchronous reset
   input wire logic run, // converter enabled
   input wire logic [2:0] sel, // prescale code
   output logic tick // one system cycle per converter clock
);
   logic [DIV_W-1:0] cnt_r;
   logic [DIV_W-1:0] last;

   // codes 0 and 1 both divide by two
   always_comb begin
      if (sel < 3'h2) begin
         last = DIV_W'(1);
      end else begin
         last = DIV_W'((8'h01 << sel) - 8'h01);
      end
   end

   // counter held at zero while off so the first tick has a full period
   always_ff @(posedge clk) begin
      if (sys_rst || !run) begin
         cnt_r <= '0;
      end else if (cnt_r >= last) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + DIV_W'(1);
      end
   end

   assign tick = run && (cnt_r >= last);
endmodule : adcsq_prescaler

//--- core/adcsq_top.sv
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "adcsq_regs.svh"

// Functional notes
// RULE1 - low byte read locks result until high read
// RULE2 - software reads low byte before high byte
// RULE3 - result is 10-bit unsigned converter code
// RULE4 - reference codes: supply, 1.1V, 2.2V, 4.3V
// RULE5 - running conversion keeps old channel, reference
// RULE6 - channel field selects single-ended input n
// RULE7 - enable bit powers converter; clear aborts
// RULE8 - start bit write begins a conversion
// RULE9 - first conversion 25 cycles, others 13
// RULE10 - start bit reads busy; zero write ignored
// RULE11 - auto trigger on selected flag rising edge
// RULE12 - done flag sets; interrupt when both enables
// RULE13 - flag cleared by vector or writing one
// RULE14 - interrupt enable gates request with global
// RULE15 - prescaler divides 2,2,4 up to 128
// RULE16 - left adjust changes presentation immediately
// RULE17 - result byte layouts for both alignments
// RULE18 - trigger source ignored without auto trigger
// RULE19 - switching to set source makes edge
// RULE20 - free-running select makes no trigger event
// RULE21 - codes 0..2: free, comparator, external zero
// RULE22 - codes 3..7: timer and pin change sources
// RULE23 - free-running completion starts next conversion
module adcsq_top (
   input wire logic clk, // system clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic hsel, // ahb slave select
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic hready, // ahb bus ready
   output logic hreadyout, // ahb slave ready
   output logic hresp, // ahb response, always okay
   output logic [31:0] hrdata, // ahb read data
   input wire logic [9:0] conv_code, // converter result code
   input wire logic [7:0] trig_flags, // trigger source flags
   input wire logic global_irq_en, // global interrupt enable
   input wire logic irq_ack, // vector taken
   output logic irq_req, // completion interrupt request
   output logic conv_power, // converter powered
   output logic conv_sample, // start of conversion pulse
   output logic conv_busy, // conversion in progress
   output logic [2:0] conv_channel, // applied input channel
   output logic [1:0] conv_reference // applied reference code
);
   logic ap_valid;
   logic ap_mapped;
   logic dp_wr_r;
   logic dp_rd_r;
   logic [7:0] dp_idx_r;
   logic hreadyout_r;
   logic [31:0] hrdata_r;
   logic [7:0] wd;
   logic wr_ctrl;
   logic wr_chref;
   logic wr_trig;
   logic rd_lo;
   logic rd_hi;
   logic [7:0] rd_byte;
   logic en_r;
   logic ate_r;
   logic ie_r;
   logic [2:0] ps_r;
   logic [1:0] ref_r;
   logic [2:0] ch_r;
   logic ladj_r;
   logic [2:0] ts_r;
   logic first_r;
   logic flag_r;
   logic lock_r;
   adcsq_pkg::adcsq_code_t result_r;
   logic en_nxt;
   logic en_rise;
   logic abort;
   logic start_wr;
   logic [7:0] src_mask;
   logic trig_lvl;
   logic trig_prev_r;
   logic trig_edge;
   logic free_next;
   logic start_go;
   logic flag_clr;
   adcsq_pkg::adcsq_state_e state_r;
   logic [4:0] cnt_r;
   logic [4:0] len_r;
   logic adc_tick;
   logic conv_done;
   logic irq_req_r;
   logic conv_sample_r;
   logic conv_busy_r;
   logic [2:0] conv_channel_r;
   logic [1:0] conv_reference_r;

   // ---------------- bus slave ----------------
   assign ap_valid = hsel && htrans[1] && hready;
   assign ap_mapped = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dp_wr_r <= 1'b0;
         dp_rd_r <= 1'b0;
         dp_idx_r <= `ADCSQ_IDX_NONE;
      end else begin
         dp_wr_r <= ap_valid && hwrite;
         dp_rd_r <= ap_valid && !hwrite;
         if (ap_valid) begin
            dp_idx_r <= ap_mapped ? haddr[9:2] : `ADCSQ_IDX_NONE;
         end
      end
   end

   // reads take one wait state so a write just before is seen
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hreadyout_r <= 1'b1;
      end else begin
         hreadyout_r <= !(ap_valid && !hwrite);
      end
   end

   assign wd = hwdata[7:0];
   assign wr_ctrl = dp_wr_r && (dp_idx_r == `ADCSQ_IDX_CTRL);
   assign wr_chref = dp_wr_r && (dp_idx_r == `ADCSQ_IDX_CHREF);
   assign wr_trig = dp_wr_r && (dp_idx_r == `ADCSQ_IDX_TRIGCFG);
   assign rd_lo = dp_rd_r && (dp_idx_r == `ADCSQ_IDX_RES_LO);
   assign rd_hi = dp_rd_r && (dp_idx_r == `ADCSQ_IDX_RES_HI);

   // presentation follows the alignment bit combinationally
   always_comb begin
      rd_byte = 8'h00;
      unique case (dp_idx_r)
         `ADCSQ_IDX_RES_LO: rd_byte = ladj_r ? {result_r[1:0], 6'h00} // RULE16 RULE17
                                     : result_r[7:0]; // RULE17
         `ADCSQ_IDX_RES_HI: rd_byte = ladj_r ? result_r[9:2] // RULE16 RULE17
                                     : {6'h00, result_r[9:8]}; // RULE17
         `ADCSQ_IDX_CHREF: rd_byte = {ref_r, 3'h0, ch_r};
         `ADCSQ_IDX_TRIGCFG: rd_byte = {ladj_r, 4'h0, ts_r};
         `ADCSQ_IDX_CTRL: rd_byte = {en_r, conv_busy_r, ate_r, flag_r, ie_r, ps_r}; // RULE10
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hrdata_r <= 32'h0000_0000;
      end else if (dp_rd_r) begin
         hrdata_r <= {24'h00_0000, rd_byte};
      end
   end

   // ---------------- software fields ----------------
   assign en_nxt = wr_ctrl ? wd[`ADCSQ_CTRL_EN] : en_r;
   assign en_rise = wr_ctrl && wd[`ADCSQ_CTRL_EN] && !en_r;
   assign abort = wr_ctrl && !wd[`ADCSQ_CTRL_EN]; // RULE7
   // writing zero to the start bit does nothing
   assign start_wr = wr_ctrl && wd[`ADCSQ_CTRL_START] && wd[`ADCSQ_CTRL_EN]; // RULE8 RULE10

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         en_r <= 1'b0;
         ate_r <= 1'b0;
         ie_r <= 1'b0;
         ps_r <= 3'h0;
      end else if (wr_ctrl) begin
         en_r <= wd[`ADCSQ_CTRL_EN]; // RULE7
         ate_r <= wd[`ADCSQ_CTRL_ATE];
         ie_r <= wd[`ADCSQ_CTRL_IE];
         ps_r <= wd[`ADCSQ_CTRL_PS_MSB:`ADCSQ_CTRL_PS_LSB];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ref_r <= `ADCSQ_REF_SUPPLY;
         ch_r <= 3'h0;
      end else if (wr_chref) begin
         ref_r <= wd[`ADCSQ_CHREF_REF_MSB:`ADCSQ_CHREF_REF_LSB];
         ch_r <= wd[`ADCSQ_CHREF_CH_MSB:`ADCSQ_CHREF_CH_LSB];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ladj_r <= 1'b0;
         ts_r <= `ADCSQ_TS_FREE;
      end else if (wr_trig) begin
         ladj_r <= wd[`ADCSQ_TRIG_LADJ]; // RULE16
         ts_r <= wd[`ADCSQ_TRIG_TS_MSB:`ADCSQ_TRIG_TS_LSB];
      end
   end

   // first conversion after enabling carries the initialisation cycles
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         first_r <= 1'b0;
      end else if (abort) begin
         first_r <= 1'b0;
      end else if (start_go) begin
         first_r <= 1'b0;
      end else if (en_rise) begin
         first_r <= 1'b1; // RULE9
      end
   end

   // ---------------- trigger ----------------
   // code 0 is free running and never yields a level of its own
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_src
         if (gi == 0) begin : g_free
            assign src_mask[gi] = 1'b0; // RULE20 RULE21
         end else begin : g_flag
            // 1 comparator, 2 external zero, 3..7 timer and pin change
            assign src_mask[gi] = trig_flags[gi] && (ts_r == 3'(gi)); // RULE21 RULE22
         end
      end
   endgenerate
   assign trig_lvl = ate_r && (|src_mask); // RULE18

   // the previous level is the selected one, so changing the selection
   // from a clear flag to a set flag looks like a rising edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trig_prev_r <= 1'b0;
      end else begin
         trig_prev_r <= trig_lvl; // RULE19
      end
   end

   assign trig_edge = trig_lvl && !trig_prev_r; // RULE11 RULE19
   assign free_next = ate_r && (ts_r == `ADCSQ_TS_FREE) && conv_done; // RULE23
   // edges that arrive mid conversion are dropped, not queued
   assign start_go = en_nxt && !abort
                     && (start_wr || trig_edge || free_next) // RULE8 RULE11 RULE23
                     && ((state_r == adcsq_pkg::ST_IDLE) || conv_done);

   // ---------------- converter clock ----------------
   adcsq_prescaler #(
      .DIV_W(7)
   ) u_presc (
      .clk(clk),
      .sys_rst(sys_rst),
      .run(en_r),
      .sel(ps_r),
      .tick(adc_tick) // RULE15
   );

   // ---------------- conversion sequencer ----------------
   assign conv_done = (state_r == adcsq_pkg::ST_CONV) && adc_tick
                      && (cnt_r == len_r - 5'h01) && !abort;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r <= adcsq_pkg::ST_IDLE;
      end else if (abort) begin
         state_r <= adcsq_pkg::ST_IDLE; // RULE7
      end else if (start_go) begin
         state_r <= adcsq_pkg::ST_CONV;
      end else if (conv_done) begin
         state_r <= adcsq_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_r <= 5'h00;
         len_r <= `ADCSQ_CONV_NORM_CYC;
      end else if (start_go) begin
         cnt_r <= 5'h00;
         len_r <= (first_r || en_rise) ? `ADCSQ_CONV_FIRST_CYC : `ADCSQ_CONV_NORM_CYC; // RULE9
      end else if ((state_r == adcsq_pkg::ST_CONV) && adc_tick) begin
         cnt_r <= cnt_r + 5'h01;
      end
   end

   // applied selection is frozen while converting
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         conv_channel_r <= 3'h0;
         conv_reference_r <= `ADCSQ_REF_SUPPLY;
      end else if ((state_r == adcsq_pkg::ST_IDLE) || conv_done || abort) begin
         conv_channel_r <= ch_r; // RULE5 RULE6
         conv_reference_r <= ref_r; // RULE4 RULE5
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         conv_busy_r <= 1'b0;
      end else begin
         conv_busy_r <= (state_r == adcsq_pkg::ST_CONV) || start_go;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         conv_sample_r <= 1'b0;
      end else begin
         conv_sample_r <= start_go;
      end
   end

   // ---------------- result and lock ----------------
   // a result finished while locked is lost; software must read high
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lock_r <= 1'b0;
      end else if (rd_hi) begin
         lock_r <= 1'b0; // RULE1 RULE2
      end else if (rd_lo) begin
         lock_r <= 1'b1; // RULE1
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         result_r <= `ADCSQ_RST_RESULT;
      end else if (conv_done && !lock_r) begin
         result_r <= conv_code; // RULE1 RULE3
      end
   end

   // ---------------- completion flag and request ----------------
   assign flag_clr = (wr_ctrl && wd[`ADCSQ_CTRL_FLAG]) || irq_ack; // RULE13

   // a completion in the clearing cycle wins
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flag_r <= 1'b0;
      end else if (conv_done) begin
         flag_r <= 1'b1; // RULE12
      end else if (flag_clr) begin
         flag_r <= 1'b0; // RULE13
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_req_r <= 1'b0;
      end else begin
         irq_req_r <= flag_r && ie_r && global_irq_en; // RULE12 RULE14
      end
   end

   // ---------------- outputs ----------------
   assign hreadyout = hreadyout_r;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;
   assign irq_req = irq_req_r;
   assign conv_power = en_r;
   assign conv_sample = conv_sample_r;
   assign conv_busy = conv_busy_r;
   assign conv_channel = conv_channel_r;
   assign conv_reference = conv_reference_r;

   // hsize is accepted but not checked; every access is a whole word
   logic unused_ok;
   assign unused_ok = ^{hsize, hwdata[31:8]};
endmodule : adcsq_top

//--- sim/adcsq_assertions.sv
`timescale 1ns/1ps

module adcsq_checker (
   input wire logic clk, // clock
   input wire logic sys_rst, // reset
   input wire logic [31:0] hrdata, // read data
   input wire logic hreadyout, // slave ready
   input wire logic global_irq_en, // global enable
   input wire logic irq_ack, // vector taken
   input wire logic irq_req, // request
   input wire logic conv_power, // converter on
   input wire logic conv_sample, // start pulse
   input wire logic conv_busy, // running
   input wire logic [2:0] conv_channel, // applied channel
   input wire logic [1:0] conv_reference // applied reference
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   logic [11:0] busy_cnt_r;

   // length of the busy run, read in the cycle where busy has just dropped
   always_ff @(posedge clk) begin
      if (sys_rst || !conv_busy) begin
         busy_cnt_r <= 12'h000;
      end else begin
         busy_cnt_r <= busy_cnt_r + 12'h001;
      end
   end

   sequence s_start;
      $rose(conv_busy);
   endsequence
   sequence s_sel_hold;
      ($stable(conv_channel) && $stable(conv_reference)) [*8];
   endsequence

   property p_sel_frozen;
      s_start |-> ##1 s_sel_hold;
   endproperty
   property p_start_pulse;
      s_start |-> conv_sample;
   endproperty
   property p_sample_busy;
      conv_sample |-> conv_busy && conv_power;
   endproperty
   property p_abort;
      $fell(conv_power) |-> ##[0:1] !conv_busy;
   endproperty
   property p_min_len;
      $fell(conv_busy) && conv_power |-> busy_cnt_r >= 12'h018;
   endproperty
   property p_irq_gate;
      irq_req |-> $past(global_irq_en);
   endproperty
   property p_irq_clear;
      irq_ack && !conv_busy |=> ##1 !irq_req;
   endproperty
   property p_hi_zero;
      hreadyout |-> hrdata[31:8] == 24'h00_0000;
   endproperty

   a_sel_frozen: assert property (p_sel_frozen)
      else $error("applied select moved during conversion");
   a_start_pulse: assert property (p_start_pulse)
      else $error("conversion began without sample pulse");
   a_sample_busy: assert property (p_sample_busy)
      else $error("sample pulse outside a conversion");
   a_abort: assert property (p_abort)
      else $error("disable did not abort conversion");
   a_min_len: assert property (p_min_len)
      else $error("conversion shorter than thirteen ticks");
   a_irq_gate: assert property (p_irq_gate)
      else $error("request without global enable");
   a_irq_clear: assert property (p_irq_clear)
      else $error("request stayed after vector taken");
   a_hi_zero: assert property (p_hi_zero)
      else $error("upper read data bits not zero");
endmodule : adcsq_checker

bind adcsq_top adcsq_checker i_adcsq_checker (.clk(clk), .sys_rst(sys_rst),
   .hrdata(hrdata), .hreadyout(hreadyout), .global_irq_en(global_irq_en),
   .irq_ack(irq_ack), .irq_req(irq_req), .conv_power(conv_power),
   .conv_sample(conv_sample), .conv_busy(conv_busy), .conv_channel(conv_channel),
   .conv_reference(conv_reference));

//--- sim/adcsq_conv_model.sv
`timescale 1ns/1ps

module adcsq_conv_model (
   input wire logic clk, // clock
   input wire logic conv_sample, // sample pulse
   input wire logic [2:0] conv_channel, // applied channel
   input wire logic [1:0] conv_reference, // applied reference
   output adcsq_pkg::adcsq_code_t conv_code // code handed back
);
   initial conv_code = 10'h000;

   // code tells which channel and reference were sampled
   always @(posedge clk) begin
      if (conv_sample === 1'b1) begin
         conv_code <= {conv_channel, conv_reference, ~conv_channel, conv_reference};
      end
   end
endmodule : adcsq_conv_model

//--- sim/test_adc_sequencer_control.sv
`timescale 1ns/1ps
`include "adcsq_regs.svh"

module test_adc_sequencer_control;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [7:0] trig_flags = 8'h00;
   logic global_irq_en = 1'b0;
   logic irq_ack = 1'b0;
   logic hreadyout, hresp, irq_req, conv_power, conv_sample, conv_busy;
   logic [31:0] hrdata;
   logic [2:0] conv_channel;
   logic [1:0] conv_reference;
   adcsq_pkg::adcsq_code_t conv_code;
   logic [7:0] q;
   int fails = 0;
   int samples_checked = 0;
   int seed = 10899;
   int starts = 0;

   always #25 clk = ~clk;
   always @(posedge clk) if (conv_sample === 1'b1) starts <= starts + 1;

   adcsq_top i_adcsq_top (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .conv_code(conv_code),
      .trig_flags(trig_flags), .global_irq_en(global_irq_en), .irq_ack(irq_ack),
      .irq_req(irq_req), .conv_power(conv_power), .conv_sample(conv_sample),
      .conv_busy(conv_busy), .conv_channel(conv_channel), .conv_reference(conv_reference));

   adcsq_conv_model i_adcsq_conv_model (.clk(clk), .conv_sample(conv_sample),
      .conv_channel(conv_channel), .conv_reference(conv_reference), .conv_code(conv_code));

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // single word transfer; called just after a rising edge
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, d};
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata[7:0];
   endtask : xfer

   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
      xfer(1'b0, idx, 8'h00);
      chk(q, exp);
   endtask : rdchk

   // counts busy cycles of the conversion just launched
   task automatic wait_idle(output int n);
      n = 0;
      for (int i = 0; i < 8 && conv_busy !== 1'b1; i++) @(posedge clk);
      while (conv_busy === 1'b1 && n < 4000) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_idle

   function automatic logic [9:0] exp_code(input logic [2:0] ch, input logic [1:0] rf);
      return {ch, rf, ~ch, rf};
   endfunction : exp_code

   function automatic logic [7:0] shown(input logic [9:0] c, input logic la, input logic hi);
      if (la) return hi ? c[9:2] : {c[1:0], 6'h00};
      return hi ? {6'h00, c[9:8]} : c[7:0];
   endfunction : shown

   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      $display("Error %0t: watchdog expired", $time);
      results();
   end

   initial begin
      logic [2:0] ch;
      logic [1:0] rf;
      logic la, ie, g;
      logic [9:0] c;
      int n, dv;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 5; i++) rdchk(8'h19 + i[7:0], 8'h00);
      // result bytes are read only; a high read leaves the lock clear
      xfer(1'b1, `ADCSQ_IDX_RES_HI, 8'hFF);
      rdchk(`ADCSQ_IDX_RES_HI, 8'h00);
      xfer(1'b1, 8'h10, 8'hFF);
      rdchk(8'h10, 8'h00);
      // every channel once, random reference, alignment and enables
      for (int k = 0; k < 8; k++) begin
         ch = k[2:0];
         rf = 2'($random(seed));
         la = 1'($random(seed));
         ie = 1'($random(seed));
         g = 1'($random(seed));
         global_irq_en <= g;
         trig_flags <= 8'($random(seed));
         xfer(1'b1, `ADCSQ_IDX_CHREF, {rf, 3'h0, ch});
         xfer(1'b1, `ADCSQ_IDX_TRIGCFG, {la, 7'h05});
         xfer(1'b1, `ADCSQ_IDX_CTRL, {4'hC, ie, 3'h0});
         xfer(1'b1, `ADCSQ_IDX_CHREF, {~rf, 3'h0, ~ch});
         chk({3'h0, conv_channel, conv_reference}, {3'h0, ch, rf});
         xfer(1'b0, `ADCSQ_IDX_CTRL, 8'h00);
         chk(q & 8'hC0, 8'hC0);
         wait_idle(n);
         chk({3'h0, conv_channel, conv_reference}, {3'h0, ~ch, ~rf});
         rdchk(`ADCSQ_IDX_CTRL, {4'h9, ie, 3'h0});
         chk({7'h0, irq_req}, {7'h0, ie & g});
         c = exp_code(ch, rf);
         rdchk(`ADCSQ_IDX_RES_LO, shown(c, la, 1'b0));
         rdchk(`ADCSQ_IDX_RES_HI, shown(c, la, 1'b1));
         xfer(1'b1, `ADCSQ_IDX_TRIGCFG, {~la, 7'h05});
         rdchk(`ADCSQ_IDX_RES_HI, shown(c, ~la, 1'b1));
         if (k[0]) begin
            irq_ack <= 1'b1;
            @(posedge clk);
            irq_ack <= 1'b0;
         end else begin
            xfer(1'b1, `ADCSQ_IDX_CTRL, {4'h9, ie, 3'h0});
         end
         rdchk(`ADCSQ_IDX_CTRL, {4'h8, ie, 3'h0});
         chk({7'h0, irq_req}, 8'h00);
      end
      // a low read holds the result over a later conversion
      trig_flags <= 8'h00;
      xfer(1'b1, `ADCSQ_IDX_CHREF, 8'h41);
      xfer(1'b1, `ADCSQ_IDX_TRIGCFG, 8'h00);
      xfer(1'b1, `ADCSQ_IDX_CTRL, 8'hC0);
      wait_idle(n);
      xfer(1'b0, `ADCSQ_IDX_RES_LO, 8'h00);
      xfer(1'b1, `ADCSQ_IDX_CHREF, 8'h86);
      xfer(1'b1, `ADCSQ_IDX_CTRL, 8'hC0);
      wait_idle(n);
      rdchk(`ADCSQ_IDX_RES_HI, shown(exp_code(3'h1, 2'h1), 1'b0, 1'b1));
      rdchk(`ADCSQ_IDX_RES_LO, shown(exp_code(3'h1, 2'h1), 1'b0, 1'b0));
      // every prescale code, first conversion after enable then a normal one
      for (int p = 0; p < 8; p++) begin
         dv = (p < 2) ? 2 : (1 << p);
         xfer(1'b1, `ADCSQ_IDX_CTRL, 8'h10);
         xfer(1'b1, `ADCSQ_IDX_CTRL, {5'h18, p[2:0]});
         wait_idle(n);
         chk({7'h0, n >= 24 * dv && n <= 25 * dv + 2}, 8'h01);
         xfer(1'b1, `ADCSQ_IDX_CTRL, {5'h18, p[2:0]});
         wait_idle(n);
         chk({7'h0, n >= 12 * dv && n <= 13 * dv + 2}, 8'h01);
      end
      // every flag trigger source 1..7: ignored without auto trigger, started with it
      for (int t = 1; t < 8; t++) begin
         xfer(1'b1, `ADCSQ_IDX_TRIGCFG, {5'h00, t[2:0]});
         xfer(1'b1, `ADCSQ_IDX_CTRL, 8'h90);
         trig_flags <= 8'h01 << t;
         repeat (4) @(posedge clk);
         chk({7'h0, conv_busy}, 8'h00);
         trig_flags <= 8'h00;
         xfer(1'b1, `ADCSQ_IDX_CTRL, 8'hB0);
         trig_flags <= 8'h01 << t;
         repeat (4) @(posedge clk);
         chk({7'h0, conv_busy}, 8'h01);
         wait_idle(n);
         trig_flags <= 8'h00;
      end
      trig_flags <= 8'h04;
      xfer(1'b1, `ADCSQ_IDX_TRIGCFG, 8'h01);
      xfer(1'b1, `ADCSQ_IDX_CTRL, 8'hA0);
      xfer(1'b1, `ADCSQ_IDX_TRIGCFG, 8'h02);
      repeat (4) @(posedge clk);
      chk({7'h0, conv_busy}, 8'h01);
      wait_idle(n);
      xfer(1'b1, `ADCSQ_IDX_TRIGCFG, 8'h00);
      repeat (4) @(posedge clk);
      chk({7'h0, conv_busy}, 8'h00);
      n = starts;
      xfer(1'b1, `ADCSQ_IDX_CTRL, 8'hE0);
      repeat (120) @(posedge clk);
      chk({7'h0, conv_busy}, 8'h01);
      chk({7'h0, starts - n >= 3}, 8'h01);
      xfer(1'b1, `ADCSQ_IDX_CTRL, 8'h00);
      repeat (2) @(posedge clk);
      chk({6'h00, conv_power, conv_busy}, 8'h00);
      results();
   end
endmodule : test_adc_sequencer_control
